//--- design/slave_buffer_pkg.sv
package slave_buffer_pkg;

    localparam int          ADDR_W        = 7;
    localparam int          SUB_W         = 16;
    localparam int          MEM_AW        = 8;
    localparam int          MEM_DEPTH     = 256;
    localparam int          FIFO_DEPTH    = 16;
    localparam logic [15:0] MEM_LIMIT     = 16'h0100;
    localparam logic [3:0]  BYTE_BITS     = 4'h8;
    localparam logic [3:0]  BIT_CNT_RESET = 4'h0;
    localparam logic [7:0]  UNDEF_READ    = 8'hff;
    localparam logic [15:0] PTR_RESET     = 16'h0000;
    localparam logic [7:0]  SHIFT_RESET   = 8'h00;
    localparam logic [2:0]  SYNC_RESET    = 3'h7;
    localparam logic [1:0]  RST_SYNC_INIT = 2'h0;

    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_ADDR     = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_WR_BYTE  = 7'h08,
        ST_WR_ACK   = 7'h10,
        ST_RD_BYTE  = 7'h20,
        ST_RD_ACK   = 7'h40
    } link_state_e;

    typedef enum logic [2:0] {
        SUB_FIRST  = 3'h1,
        SUB_SECOND = 3'h2,
        SUB_DATA   = 3'h4
    } sub_phase_e;

    typedef struct packed {
        logic [15:0] exposed_length;
        logic [15:0] writable_region_limit;
        logic        nonvolatile;
    } buffer_cfg_s;

    typedef struct packed {
        logic              sel;
        logic [MEM_AW-1:0] addr;
        logic [7:0]        data;
    } wr_entry_s;

    localparam int ENTRY_W = $bits(wr_entry_s);

endpackage : slave_buffer_pkg

//--- design/write_fifo.sv
`timescale 1ns/1ps
module write_fifo
    import slave_buffer_pkg::*;
#(
    parameter int WIDTH = ENTRY_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_ZERO = '0;
    localparam logic [AW-1:0] PTR_ZERO = '0;

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    assign in_ready  = (count_reg != FULL_CNT);
    assign out_valid = (count_reg != CNT_ZERO);
    assign out_data  = store[rd_ptr_reg];

    always_ff @(posedge mclk) begin
        if (ce && push) begin
            store[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= PTR_ZERO;
            rd_ptr_reg <= PTR_ZERO;
            count_reg  <= CNT_ZERO;
        end else if (ce) begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push != pop) count_reg <= push ? count_reg + 1'b1 : count_reg - 1'b1;
        end
    end

endmodule : write_fifo

//--- design/i2c_shared_buffer_slave.sv
`timescale 1ns/1ps
module i2c_shared_buffer_slave
    import slave_buffer_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              ce,
    input  wire logic              scl_in,
    output      logic              scl_out,
    output      logic              scl_oe,
    input  wire logic              sda_in,
    output      logic              sda_out,
    output      logic              sda_oe,
    input  wire logic [ADDR_W-1:0] primary_address,
    input  wire logic [ADDR_W-1:0] secondary_address,
    input  wire logic              two_address_mode,
    input  wire logic              subaddress_16bit,
    input  wire buffer_cfg_s       primary_cfg,
    input  wire buffer_cfg_s       secondary_cfg,
    input  wire logic              local_sel,
    input  wire logic [MEM_AW-1:0] local_addr,
    input  wire logic              local_we,
    input  wire logic [7:0]        local_wdata,
    output      logic [7:0]        local_rdata,
    output      logic [SUB_W-1:0]  primary_subaddress_pointer,
    output      logic [SUB_W-1:0]  secondary_subaddress_pointer,
    output      logic [SUB_W-1:0]  primary_transfer_index,
    output      logic [SUB_W-1:0]  secondary_transfer_index,
    output      logic              bus_busy
);
    logic [1:0]             rst_sync_reg;
    logic                   rst_n;
    logic [2:0]             scl_sync_reg;
    logic [2:0]             sda_sync_reg;
    logic                   scl_f_reg;
    logic                   scl_d_reg;
    logic                   sda_f_reg;
    logic                   sda_d_reg;
    link_state_e            state_reg;
    sub_phase_e             sub_reg;
    logic [3:0]             bit_cnt_reg;
    logic [7:0]             shift_reg;
    logic [7:0]             tx_reg;
    logic [7:0]             sub_hi_reg;
    logic                   sel_reg;
    logic                   rw_reg;
    logic                   master_ack_reg;
    logic                   fall_pend_reg;
    logic                   sda_oe_reg;
    logic                   busy_reg;
    logic                   stall_reg;
    logic [1:0][SUB_W-1:0]  ptr_reg;
    logic [1:0][SUB_W-1:0]  idx_reg;
    logic [7:0]             mem [2][MEM_DEPTH];

    // local writes win the memory port, so the drain stalls and the fifo backs up
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) rst_sync_reg <= RST_SYNC_INIT;
        else         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // three-stage input sync; a level counts once stages two and three agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_reg <= SYNC_RESET;
            sda_sync_reg <= SYNC_RESET;
            scl_f_reg    <= 1'b1;
            sda_f_reg    <= 1'b1;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end else if (ce) begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            if (scl_sync_reg[1] == scl_sync_reg[2]) scl_f_reg <= scl_sync_reg[2];
            if (sda_sync_reg[1] == sda_sync_reg[2]) sda_f_reg <= sda_sync_reg[2];
            scl_d_reg    <= scl_f_reg;
            sda_d_reg    <= sda_f_reg;
        end
    end

    wire scl_rise  = scl_f_reg & ~scl_d_reg;
    wire scl_fall  = ~scl_f_reg & scl_d_reg;
    wire start_det = scl_f_reg & scl_d_reg & sda_d_reg & ~sda_f_reg;
    wire stop_det  = scl_f_reg & scl_d_reg & ~sda_d_reg & sda_f_reg;

    wire             prim_hit = (shift_reg[7:1] == primary_address);
    wire             sec_hit  = two_address_mode & (shift_reg[7:1] == secondary_address);
    wire             addr_hit = prim_hit | sec_hit;
    wire buffer_cfg_s cur_cfg = sel_reg ? secondary_cfg : primary_cfg;
    wire [SUB_W-1:0] cur_ptr  = ptr_reg[sel_reg];
    wire [SUB_W-1:0] cur_idx  = idx_reg[sel_reg];
    wire             byte_done = (bit_cnt_reg == BYTE_BITS);

    // a read restarts from the stored offset, not where the last read ended
    wire [SUB_W-1:0] rd_idx = (state_reg == ST_ADDR_ACK) ? cur_ptr : cur_idx;
    wire             rd_ok  = (rd_idx < cur_cfg.exposed_length) && (rd_idx < MEM_LIMIT);
    wire [7:0]       rd_data = rd_ok ? mem[sel_reg][rd_idx[MEM_AW-1:0]] : UNDEF_READ;
    wire             wr_ok  = !cur_cfg.nonvolatile
                              && (cur_idx < cur_cfg.writable_region_limit)
                              && (cur_idx < cur_cfg.exposed_length)
                              && (cur_idx < MEM_LIMIT);

    wire             data_byte = (state_reg == ST_WR_BYTE) && byte_done && (sub_reg == SUB_DATA);
    wire             load_rd   = ((state_reg == ST_ADDR_ACK) && rw_reg)
                                 || ((state_reg == ST_RD_ACK) && master_ack_reg);
    wire             fifo_in_ready;
    wire             fifo_out_valid;
    wire             fifo_out_ready;
    wire wr_entry_s  fifo_out;
    wire             fifo_in_valid = fall_pend_reg & data_byte & wr_ok;
    // pending writes must land before a read samples memory
    wire             block = (fifo_in_valid & ~fifo_in_ready)
                             | (fall_pend_reg & load_rd & fifo_out_valid);
    wire             fall_go = fall_pend_reg & ~block;
    wire wr_entry_s  fifo_in = '{sel: sel_reg, addr: cur_idx[MEM_AW-1:0], data: shift_reg};

    // stretch outlives the stall by one cycle so sda settles before scl may rise
    assign scl_oe  = block | stall_reg;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_reg;
    assign bus_busy = busy_reg;
    assign fifo_out_ready = ~local_we;
    assign primary_subaddress_pointer   = ptr_reg[0];
    assign secondary_subaddress_pointer = ptr_reg[1];
    assign primary_transfer_index       = idx_reg[0];
    assign secondary_transfer_index     = idx_reg[1];

    write_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_write_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out)
    );

    always_ff @(posedge mclk) begin
        if (ce) begin
            if (local_we) begin
                mem[local_sel][local_addr] <= local_wdata;
            end else if (fifo_out_valid) begin
                mem[fifo_out.sel][fifo_out.addr] <= fifo_out.data;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) local_rdata <= SHIFT_RESET;
        else if (ce) local_rdata <= mem[local_sel][local_addr];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) stall_reg <= 1'b0;
        else if (ce) stall_reg <= block;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) busy_reg <= 1'b0;
        else if (ce && (start_det || stop_det)) busy_reg <= start_det;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= ST_IDLE;
            sub_reg        <= SUB_FIRST;
            bit_cnt_reg    <= BIT_CNT_RESET;
            shift_reg      <= SHIFT_RESET;
            tx_reg         <= SHIFT_RESET;
            sub_hi_reg     <= SHIFT_RESET;
            sel_reg        <= 1'b0;
            rw_reg         <= 1'b0;
            master_ack_reg <= 1'b0;
            fall_pend_reg  <= 1'b0;
            sda_oe_reg     <= 1'b0;
            ptr_reg        <= {PTR_RESET, PTR_RESET};
            idx_reg        <= {PTR_RESET, PTR_RESET};
        end else if (ce) begin
            if (start_det) begin
                state_reg     <= ST_ADDR;
                bit_cnt_reg   <= BIT_CNT_RESET;
                fall_pend_reg <= 1'b0;
                sda_oe_reg    <= 1'b0;
            end else if (stop_det) begin
                state_reg     <= ST_IDLE;
                fall_pend_reg <= 1'b0;
                sda_oe_reg    <= 1'b0;
            end else begin
                if (scl_fall) fall_pend_reg <= 1'b1;
                else if (fall_go) fall_pend_reg <= 1'b0;
                if (scl_rise) begin
                    case (state_reg)
                        ST_ADDR, ST_WR_BYTE: begin
                            shift_reg   <= {shift_reg[6:0], sda_f_reg};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        ST_RD_BYTE: bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        ST_RD_ACK:  master_ack_reg <= ~sda_f_reg;
                        default: ;
                    endcase
                end
                if (fall_go) begin
                    case (state_reg)
                        ST_ADDR: begin
                            if (byte_done && addr_hit) begin
                                sel_reg    <= sec_hit & ~prim_hit;
                                rw_reg     <= shift_reg[0];
                                sda_oe_reg <= 1'b1;
                                state_reg  <= ST_ADDR_ACK;
                            end else if (byte_done) begin
                                state_reg  <= ST_IDLE;
                            end
                        end
                        ST_ADDR_ACK: begin
                            bit_cnt_reg <= BIT_CNT_RESET;
                            if (rw_reg) begin
                                tx_reg     <= rd_data;
                                sda_oe_reg <= ~rd_data[7];
                                idx_reg[sel_reg] <= cur_ptr + 16'h0001;
                                state_reg  <= ST_RD_BYTE;
                            end else begin
                                sda_oe_reg <= 1'b0;
                                sub_reg    <= SUB_FIRST;
                                state_reg  <= ST_WR_BYTE;
                            end
                        end
                        ST_WR_BYTE: begin
                            if (byte_done) begin
                                case (sub_reg)
                                    SUB_FIRST: begin
                                        if (subaddress_16bit) begin
                                            sub_hi_reg <= shift_reg;
                                            sub_reg    <= SUB_SECOND;
                                        end else begin
                                            ptr_reg[sel_reg] <= {8'h00, shift_reg};
                                            idx_reg[sel_reg] <= {8'h00, shift_reg};
                                            sub_reg          <= SUB_DATA;
                                        end
                                    end
                                    SUB_SECOND: begin
                                        ptr_reg[sel_reg] <= {sub_hi_reg, shift_reg};
                                        idx_reg[sel_reg] <= {sub_hi_reg, shift_reg};
                                        sub_reg          <= SUB_DATA;
                                    end
                                    default: idx_reg[sel_reg] <= cur_idx + 16'h0001;
                                endcase
                                sda_oe_reg <= 1'b1;
                                state_reg  <= ST_WR_ACK;
                            end
                        end
                        ST_WR_ACK: begin
                            sda_oe_reg  <= 1'b0;
                            bit_cnt_reg <= BIT_CNT_RESET;
                            state_reg   <= ST_WR_BYTE;
                        end
                        ST_RD_BYTE: begin
                            if (byte_done) begin
                                sda_oe_reg <= 1'b0;
                                state_reg  <= ST_RD_ACK;
                            end else begin
                                tx_reg     <= {tx_reg[6:0], 1'b0};
                                sda_oe_reg <= ~tx_reg[6];
                            end
                        end
                        ST_RD_ACK: begin
                            bit_cnt_reg <= BIT_CNT_RESET;
                            if (master_ack_reg) begin
                                tx_reg     <= rd_data;
                                sda_oe_reg <= ~rd_data[7];
                                idx_reg[sel_reg] <= cur_idx + 16'h0001;
                                state_reg  <= ST_RD_BYTE;
                            end else begin
                                state_reg  <= ST_IDLE;
                            end
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

endmodule : i2c_shared_buffer_slave

//--- sim/slave_bus_props.sv
`timescale 1ns/1ps
module slave_bus_props
    import slave_buffer_pkg::*;
(
    input wire logic             mclk,
    input wire logic             resetn,
    input wire logic             scl_in,
    input wire logic             scl_oe,
    input wire logic             sda_in,
    input wire logic             sda_oe,
    input wire logic             two_address_mode,
    input wire logic [SUB_W-1:0] primary_subaddress_pointer,
    input wire logic [SUB_W-1:0] secondary_subaddress_pointer,
    input wire logic [SUB_W-1:0] primary_transfer_index,
    input wire logic             bus_busy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    sequence s_start;
        scl_in && $fell(sda_in);
    endsequence
    sequence s_stop;
        scl_in && $rose(sda_in);
    endsequence
    property p_reset_quiet;
        disable iff (1'b0) !resetn |-> !scl_oe && !sda_oe && !bus_busy;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("pins driven in reset");
    property p_busy_start;
        s_start |-> ##[1:8] bus_busy;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy late after start");
    property p_idle_stop;
        s_stop |-> ##[1:8] !bus_busy;
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("busy kept after stop");
    // data may only move while the clock is low, else it reads as start or stop
    property p_sda_steady;
        scl_in && $past(scl_in) |-> $stable(sda_oe);
    endproperty
    a_sda_steady: assert property (p_sda_steady) else $error("data moved, clock high");
    property p_stretch_low;
        $rose(scl_oe) |-> !$past(scl_in, 2);
    endproperty
    a_stretch_low: assert property (p_stretch_low) else $error("stretch on high clock");
    property p_ptr_busy;
        $changed(primary_subaddress_pointer) |-> bus_busy;
    endproperty
    a_ptr_busy: assert property (p_ptr_busy) else $error("offset moved while idle");
    property p_sec_mode;
        $changed(secondary_subaddress_pointer) |-> two_address_mode && bus_busy;
    endproperty
    a_sec_mode: assert property (p_sec_mode) else $error("second offset moved");
    property p_idx_busy;
        $changed(primary_transfer_index) |-> bus_busy || $past(bus_busy);
    endproperty
    a_idx_busy: assert property (p_idx_busy) else $error("index moved while idle");
endmodule : slave_bus_props

//--- sim/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
    input  wire logic mclk,
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    output logic      scl_line,
    output logic      sda_line,
    output logic      stuck
);
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    initial stuck = 1'b0;
    // pull-ups: a released line reads high, never the last driven value
    assign scl_line = ~(scl_low | scl_oe);
    assign sda_line = ~(sda_low | sda_oe);
    task automatic half;
        repeat (8) @(posedge mclk);
    endtask : half
    // the slave may stretch; bounded so a hang is reported, not waited out
    task automatic rise;
        int n;
        n = 0;
        scl_low <= 1'b0;
        @(posedge mclk);
        while (!scl_line && n < 8000) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 8000) stuck <= 1'b1;
        half();
    endtask : rise
    task automatic clock(input logic b, output logic s);
        half();
        sda_low <= ~b;
        half();
        rise();
        s = sda_line;
        scl_low <= 1'b1;
    endtask : clock
    task automatic start;
        half();
        sda_low <= 1'b0;
        half();
        rise();
        sda_low <= 1'b1;
        half();
        scl_low <= 1'b1;
    endtask : start
    task automatic stop;
        half();
        sda_low <= 1'b1;
        half();
        rise();
        sda_low <= 1'b0;
        half();
    endtask : stop
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clock(d[i], s);
        clock(1'b1, s);
        ack = ~s;
    endtask : put
    task automatic get(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) clock(1'b1, d[i]);
        clock(last, s);
    endtask : get
endmodule : i2c_master_model

//--- sim/i2c_shared_buffer_slave_bench.sv
`timescale 1ns/1ps
module i2c_shared_buffer_slave_bench import slave_buffer_pkg::*;;
    localparam logic [6:0] PRI = 7'h50;
    localparam logic [6:0] SEC = 7'h23;
    logic mclk = 1'b0;
    logic resetn = 1'b1;
    logic two_address_mode = 1'b0;
    logic subaddress_16bit = 1'b0;
    buffer_cfg_s primary_cfg = '{16'h000a, 16'h0004, 1'b0};
    buffer_cfg_s secondary_cfg = '{16'h0100, 16'h0100, 1'b0};
    logic local_sel = 1'b0;
    logic local_we = 1'b0;
    logic [7:0] local_addr = 8'h00;
    logic [7:0] local_wdata = 8'h00;
    logic [7:0] local_rdata;
    logic scl_line, sda_line, scl_oe, sda_oe, bus_busy, stuck, ack;
    logic stretched = 1'b0;
    logic [SUB_W-1:0] primary_subaddress_pointer, secondary_subaddress_pointer;
    logic [SUB_W-1:0] primary_transfer_index, secondary_transfer_index;
    int fail_count = 0;
    int compares = 0;
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) if (scl_oe) stretched <= 1'b1;
    i2c_shared_buffer_slave dut_u (
        .mclk, .resetn, .ce(1'b1), .scl_in(scl_line), .scl_out(), .scl_oe,
        .sda_in(sda_line), .sda_out(), .sda_oe, .primary_address(PRI),
        .secondary_address(SEC), .two_address_mode, .subaddress_16bit, .primary_cfg,
        .secondary_cfg, .local_sel, .local_addr, .local_we, .local_wdata, .local_rdata,
        .primary_subaddress_pointer, .secondary_subaddress_pointer,
        .primary_transfer_index, .secondary_transfer_index, .bus_busy);
    i2c_master_model m_u (.mclk, .scl_oe, .sda_oe, .scl_line, .sda_line, .stuck);
    task automatic check(input string what, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task automatic lrd(input logic s, input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        local_sel <= s;
        local_addr <= a;
        @(posedge mclk);
        @(negedge mclk);
        check("memory", 16'(local_rdata), 16'(e));
    endtask : lrd
    task automatic wr(input logic [6:0] dev, input logic [7:0] b[$]);
        logic a;
        m_u.start();
        m_u.put({dev, 1'b0}, ack);
        foreach (b[i]) if (ack) m_u.put(b[i], a);
        m_u.stop();
    endtask : wr
    task automatic rd(input logic [6:0] dev, input logic [7:0] e[$]);
        logic [7:0] d;
        m_u.start();
        m_u.put({dev, 1'b1}, ack);
        check("read ack", 16'(ack), 16'h0001);
        foreach (e[i]) begin
            m_u.get(i == e.size() - 1, d);
            check("read data", 16'(d), 16'(e[i]));
        end
        m_u.stop();
    endtask : rd
    task automatic t_primary;
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            local_we <= 1'b1;
            local_addr <= 8'(i);
            local_wdata <= 8'h10 + 8'(i);
        end
        @(posedge mclk);
        local_we <= 1'b0;
        wr(PRI, '{8'h02, 8'ha1, 8'ha2, 8'ha3});
        lrd(1'b0, 8'h03, 8'ha2);
        lrd(1'b0, 8'h04, 8'h14);
        check("offset", primary_subaddress_pointer, 16'h0002);
        check("index", primary_transfer_index, 16'h0005);
        check("busy after stop", 16'(bus_busy), 16'h0000);
        rd(PRI, '{8'ha1, 8'ha2, 8'h14});
        rd(PRI, '{8'ha1, 8'ha2});
        wr(PRI, '{8'h09});
        rd(PRI, '{8'h19, 8'hff});
        wr(7'h51, '{8'h00});
        check("stray address", 16'(ack), 16'h0000);
        wr(SEC, '{8'h00});
        check("second off", 16'(ack), 16'h0000);
        $display("test primary done");
    endtask : t_primary
    task automatic t_secondary;
        @(posedge mclk);
        two_address_mode <= 1'b1;
        subaddress_16bit <= 1'b1;
        local_sel <= 1'b0;
        local_addr <= 8'hfe;
        local_wdata <= 8'h3c;
        local_we <= 1'b1;
        @(posedge mclk);
        local_we <= 1'b0;
        wr(SEC, '{8'h00, 8'hfe, 8'h5a, 8'ha5});
        lrd(1'b1, 8'hff, 8'ha5);
        lrd(1'b0, 8'hfe, 8'h3c);
        check("second offset", secondary_subaddress_pointer, 16'h00fe);
        rd(SEC, '{8'h5a, 8'ha5, 8'hff});
        check("second index", secondary_transfer_index, 16'h0101);
        primary_cfg.nonvolatile <= 1'b1;
        wr(PRI, '{8'h00, 8'h00, 8'h77});
        lrd(1'b0, 8'h00, 8'h10);
        @(posedge mclk);
        primary_cfg.nonvolatile <= 1'b0;
        $display("test secondary done");
    endtask : t_secondary
    // a long local write starves the drain, so the queue fills and the bus stalls
    task automatic t_stretch;
        logic [7:0] b[$];
        b = '{8'h00, 8'h10};
        for (int i = 0; i < 24; i++) b.push_back(8'h80 + 8'(i));
        fork
            begin
                local_sel <= 1'b1;
                local_we <= 1'b1;
                repeat (5000) @(posedge mclk);
                local_we <= 1'b0;
            end
            wr(SEC, b);
        join
        check("stretch seen", 16'(stretched), 16'h0001);
        lrd(1'b1, 8'h27, 8'h97);
        $display("test stretch done");
    endtask : t_stretch
    initial begin
        resetn <= 1'b0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        repeat (5) @(posedge mclk);
        t_primary();
        t_secondary();
        t_stretch();
        final_report();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        fail_count++;
        final_report();
    end
    always @(posedge stuck) begin
        fail_count++;
        final_report();
    end
endmodule : i2c_shared_buffer_slave_bench
bind i2c_shared_buffer_slave slave_bus_props props_u (
    .mclk, .resetn, .scl_in, .scl_oe, .sda_in, .sda_oe, .two_address_mode,
    .primary_subaddress_pointer, .secondary_subaddress_pointer,
    .primary_transfer_index, .bus_busy);
